// >>> rtl/sspc_ctrl.sv
`timescale 1ns/10ps
`include "sspc_defines.svh"

module sspc_ctrl
   import sspc_pkg::*;
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // AXI4-Lite slave
   input wire logic [31:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [31:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // Serial pins
   input wire logic i_serial_clock_pin,
   output logic o_serial_clock_pin,
   output logic o_serial_clock_pin_oe,
   input wire logic i_serial_in_pin,
   output logic o_serial_out_pin,
   // Completion request
   output logic o_xfer_done
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic wr_en, rd_en, tick;
   logic [1:0] wr_sel, rd_sel;
   logic [7:0] wr_data, rd_data;
   logic [7:0] ctrl_r, ctrl_nxt;
   logic [15:0] sh_r, sh_nxt, sh_q;
   logic [4:0] cnt_r, cnt_nxt;
   sspc_state_t state_r, state_nxt;
   logic so_r, so_nxt, sck_r, sck_nxt, oe_r, oe_nxt;
   logic ovr_r, ovr_nxt, seen_r, seen_nxt, done_r, done_nxt;
   logic sck_q_r, busy, ext, cont, tail_en;
   logic fall, rise, ext_rise, ext_fall, wr_ctrl, wr_stat, rd_stat, startable;
   logic [4:0] last;
   sspc_mode_t mode;

   // ----------------------------------------
   // Bus slave and prescaler
   // ----------------------------------------
   sspc_axil u_axil (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_awaddr(i_awaddr),
      .i_awvalid(i_awvalid),
      .o_awready(o_awready),
      .i_wdata(i_wdata),
      .i_wstrb(i_wstrb),
      .i_wvalid(i_wvalid),
      .o_wready(o_wready),
      .o_bresp(o_bresp),
      .o_bvalid(o_bvalid),
      .i_bready(i_bready),
      .i_araddr(i_araddr),
      .i_arvalid(i_arvalid),
      .o_arready(o_arready),
      .o_rdata(o_rdata),
      .o_rresp(o_rresp),
      .o_rvalid(o_rvalid),
      .i_rready(i_rready),
      .o_wr_en(wr_en),
      .o_wr_sel(wr_sel),
      .o_wr_data(wr_data),
      .o_rd_en(rd_en),
      .o_rd_sel(rd_sel),
      .i_rd_data(rd_data)
   );

   sspc_prescale u_pre (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_sel(ctrl_r[`SSPC_B_PRE_HI:0]),
      .o_tick(tick)
   );

   // ----------------------------------------
   // Decoded controls and serial clock events
   // ----------------------------------------
   assign mode = sspc_mode_t'(ctrl_r[`SSPC_B_MODE_HI:`SSPC_B_MODE_LO]);
   assign cont = (mode == SSPC_MODE_CONT);
   assign ext = ctrl_r[`SSPC_B_CLK_SRC];
   assign tail_en = ctrl_r[`SSPC_B_TAIL_EN];
   assign busy = (state_r != SSPC_IDLE);
   assign wr_ctrl = wr_en & (wr_sel == `SSPC_SEL_CTRL);
   assign wr_stat = wr_en & (wr_sel == `SSPC_SEL_STAT);
   assign rd_stat = rd_en & (rd_sel == `SSPC_SEL_STAT);
   // The reserved mode and continuous mode never start a transfer
   assign startable = (mode == SSPC_MODE_8) | (mode == SSPC_MODE_16);
   // Pin is taken as synchronous, so a one-flop history finds its edges
   assign ext_rise = ext & ~sck_q_r & i_serial_clock_pin;
   assign ext_fall = ext & sck_q_r & ~i_serial_clock_pin;
   assign fall = ext ? ext_fall : (tick & sck_r);
   assign rise = ext ? ext_rise : (tick & ~sck_r);

   always_comb begin
      if (state_r == SSPC_TAIL) begin
         last = ctrl_r[`SSPC_B_LATCH] ? `SSPC_TAIL_LATCH_LAST : `SSPC_TAIL_HOLD_LAST;
      end else if (mode == SSPC_MODE_16) begin
         last = `SSPC_LAST_16;
      end else begin
         last = `SSPC_LAST_8;
      end
   end

   // ----------------------------------------
   // Register read mux
   // ----------------------------------------
   always_comb begin
      case (rd_sel)
         `SSPC_SEL_CTRL: rd_data = ctrl_r;
         `SSPC_SEL_STAT: begin
            rd_data = `SSPC_STAT_RST;
            rd_data[`SSPC_B_SOL] = so_r;
            rd_data[`SSPC_B_OVR] = ovr_r;
            rd_data[`SSPC_B_TAIL] = (state_r == SSPC_TAIL);
            rd_data[`SSPC_B_STF] = busy;
         end
         `SSPC_SEL_DATU: rd_data = sh_r[15:8];
         default: rd_data = sh_r[7:0];
      endcase
   end

   // ----------------------------------------
   // Transfer engine and registers
   // ----------------------------------------
   always_comb begin
      ctrl_nxt = ctrl_r;
      state_nxt = state_r;
      sh_nxt = sh_r;
      cnt_nxt = cnt_r;
      so_nxt = so_r;
      sck_nxt = sck_r;
      ovr_nxt = ovr_r;
      seen_nxt = seen_r;
      done_nxt = 1'b0;
      // Internal clock toggles only while busy (data or tail) or in continuous mode
      if (~ext & tick & (busy | cont)) begin
         sck_nxt = ~sck_r;
      end
      if (busy & fall) begin
         // Hold tail idles high, latch tail low
         so_nxt = (state_r == SSPC_TAIL) ? ~ctrl_r[`SSPC_B_LATCH] : sh_r[0];
      end
      if (busy & rise) begin
         cnt_nxt = cnt_r + 5'h01;
         if (state_r == SSPC_DATA) begin
            if (mode == SSPC_MODE_16) begin
               sh_nxt = {i_serial_in_pin, sh_r[15:1]};
            end else begin
               sh_nxt = {sh_r[15:8], i_serial_in_pin, sh_r[7:1]};
            end
         end
         if (cnt_r == last) begin
            cnt_nxt = 5'h00;
            if ((state_r == SSPC_DATA) & tail_en) begin
               state_nxt = SSPC_TAIL;
            end else begin
               state_nxt = SSPC_IDLE;
               done_nxt = 1'b1;
            end
         end
      end
      if (rd_stat & ovr_r) begin
         seen_nxt = 1'b1;
      end
      if (wr_ctrl) begin
         ctrl_nxt = wr_data;
         state_nxt = SSPC_IDLE;
         cnt_nxt = 5'h00;
         sck_nxt = 1'b1;
         done_nxt = 1'b0;
      end
      if (wr_stat) begin
         // Level override is dead in tail-mark mode and lost at next start
         if (~tail_en) begin
            so_nxt = wr_data[`SSPC_B_SOL];
         end
         if (~wr_data[`SSPC_B_OVR] & seen_r) begin
            ovr_nxt = 1'b0;
            seen_nxt = 1'b0;
         end
         if (wr_data[`SSPC_B_STF] & startable & ~busy & ~wr_ctrl) begin
            state_nxt = SSPC_DATA;
            cnt_nxt = 5'h00;
         end
      end
      // A late pulse wins over a clear in the same cycle
      if (ext_rise & ~busy & ~cont) begin
         ovr_nxt = 1'b1;
      end
   end

   assign oe_nxt = ~ctrl_nxt[`SSPC_B_CLK_SRC];

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         ctrl_r <= `SSPC_CTRL_RST;
         state_r <= SSPC_IDLE;
         sh_r <= 16'h0000;
         cnt_r <= 5'h00;
         so_r <= 1'b0;
         sck_r <= 1'b1;
         oe_r <= 1'b1;
         ovr_r <= 1'b0;
         seen_r <= 1'b0;
         done_r <= 1'b0;
         sck_q_r <= 1'b1;
      end else begin
         ctrl_r <= ctrl_nxt;
         state_r <= state_nxt;
         sh_r <= sh_q;
         cnt_r <= cnt_nxt;
         so_r <= so_nxt;
         sck_r <= sck_nxt;
         oe_r <= oe_nxt;
         ovr_r <= ovr_nxt;
         seen_r <= seen_nxt;
         done_r <= done_nxt;
         sck_q_r <= i_serial_clock_pin;
      end
   end

   // ----------------------------------------
   // Data register writes
   // ----------------------------------------
   // Writes during a transfer corrupt the shift; software avoids them
   // sh_r is also written above, so byte loads go through a second stage
   always_comb begin
      sh_q = sh_nxt;
      if (wr_en & (wr_sel == `SSPC_SEL_DATU)) begin
         sh_q[15:8] = wr_data;
      end
      if (wr_en & (wr_sel == `SSPC_SEL_DATL)) begin
         sh_q[7:0] = wr_data;
      end
   end

   assign o_serial_clock_pin = sck_r;
   assign o_serial_clock_pin_oe = oe_r;
   assign o_serial_out_pin = so_r;
   assign o_xfer_done = done_r;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   sequence last_data_rise;
      (state_r == SSPC_DATA) && rise && (cnt_r == last) && !wr_ctrl;
   endsequence

   sequence ended_clean;
      ##1 (state_r == SSPC_IDLE) && o_xfer_done;
   endsequence

   ctrl_stop_a: assert property (wr_ctrl |=> !busy && !o_xfer_done)
      else $error("control write did not stop the transfer");
   start_flag_a: assert property (wr_stat && wr_data[0] && startable && !busy && !wr_ctrl
      |=> state_r == SSPC_DATA)
      else $error("start write did not start a transfer");
   xfer_end_a: assert property (last_data_rise and !tail_en |-> ended_clean)
      else $error("transfer did not end on last bit");
   tail_entry_a: assert property (last_data_rise and tail_en |=> state_r == SSPC_TAIL)
      else $error("tail mark did not follow data");
   lsb_out_a: assert property ((state_r == SSPC_DATA) && fall && !wr_en
      |=> o_serial_out_pin == $past(sh_r[0]))
      else $error("wrong bit driven on falling edge");
   ovr_set_a: assert property (ext_rise && !busy && !cont |=> ovr_r)
      else $error("overrun not flagged");
   ovr_keep_a: assert property (ovr_r && !(wr_stat && !wr_data[5] && seen_r) |=> ovr_r)
      else $error("overrun flag lost");
   sol_write_a: assert property (wr_stat && !tail_en && !busy && !wr_ctrl && !ext_rise
      |=> o_serial_out_pin == $past(wr_data[6]))
      else $error("output level override not applied");
   idle_hold_a: assert property (!busy && !$past(busy) && !wr_stat |=> $stable(o_serial_out_pin))
      else $error("output changed while idle");
   clk_dir_a: assert property ($past(ext) && ext |-> !o_serial_clock_pin_oe)
      else $error("clock pin driven with external clock");
   rsv_read_a: assert property (rd_stat |=> o_rdata[7] && o_rdata[4:2] == 3'h7)
      else $error("reserved status bits misread");
   tail_flag_a: assert property (rd_stat |=> o_rdata[1] == $past(state_r == SSPC_TAIL))
      else $error("tail flag misread");
endmodule

// >>> rtl/sspc_defines.svh
`ifndef SSPC_DEFINES_SVH
`define SSPC_DEFINES_SVH

// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define SSPC_IDX_CTRL 16'hFFA0
`define SSPC_IDX_STAT 16'hFFA1
`define SSPC_IDX_DATU 16'hFFA2
`define SSPC_IDX_DATL 16'hFFA3
`define SSPC_SEL_CTRL 2'h0
`define SSPC_SEL_STAT 2'h1
`define SSPC_SEL_DATU 2'h2
`define SSPC_SEL_DATL 2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SSPC_CTRL_RST 8'h00
`define SSPC_STAT_RST 8'h9C

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define SSPC_B_MODE_HI 7
`define SSPC_B_MODE_LO 6
`define SSPC_B_TAIL_EN 5
`define SSPC_B_LATCH 4
`define SSPC_B_CLK_SRC 3
`define SSPC_B_PRE_HI 2

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define SSPC_B_RSV 7
`define SSPC_B_SOL 6
`define SSPC_B_OVR 5
`define SSPC_B_RSV_HI 4
`define SSPC_B_RSV_LO 2
`define SSPC_B_TAIL 1
`define SSPC_B_STF 0

// ----------------------------------------
// Last data bit and last tail clock indices (count minus one), in serial clocks
// ----------------------------------------
`define SSPC_LAST_8 5'h07
`define SSPC_LAST_16 5'h0F
`define SSPC_TAIL_HOLD_LAST 5'h00
`define SSPC_TAIL_LATCH_LAST 5'h01

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define SSPC_RESP_OK 2'h0
`define SSPC_RESP_ERR 2'h2

`endif

// >>> rtl/sspc_pkg.sv
package sspc_pkg;
   typedef enum logic [1:0] {
      SSPC_IDLE = 2'b00,
      SSPC_DATA = 2'b01,
      SSPC_TAIL = 2'b10
   } sspc_state_t;

   typedef enum logic [1:0] {
      SSPC_MODE_8 = 2'b00,
      SSPC_MODE_16 = 2'b01,
      SSPC_MODE_CONT = 2'b10,
      SSPC_MODE_RSV = 2'b11
   } sspc_mode_t;
endpackage

// >>> rtl/sspc_prescale.sv
`timescale 1ns/10ps
`include "sspc_defines.svh"

// Half-period tick of the internal serial clock: one full clock is two ticks
module sspc_prescale
   import sspc_pkg::*;
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // Division select
   input wire logic [2:0] i_sel,
   // Half-period pulse
   output logic o_tick
);
   logic [8:0] cnt_r;
   logic [8:0] cnt_nxt;
   logic [8:0] mask;
   logic tick_r;
   logic tick_nxt;

   always_comb begin
      case (i_sel)
         3'h0: mask = 9'h1FF;
         3'h1: mask = 9'h07F;
         3'h2: mask = 9'h01F;
         3'h3: mask = 9'h00F;
         3'h4: mask = 9'h007;
         3'h5: mask = 9'h003;
         3'h6: mask = 9'h001;
         default: mask = 9'h000;
      endcase
      cnt_nxt = cnt_r + 9'h001;
      tick_nxt = (cnt_r & mask) == mask;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         cnt_r <= 9'h000;
         tick_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign o_tick = tick_r;
endmodule

// >>> rtl/sspc_axil.sv
`timescale 1ns/10ps
`include "sspc_defines.svh"

module sspc_axil
   import sspc_pkg::*;
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // Write address and data
   input wire logic [31:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   // Write response
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   // Read address and data
   input wire logic [31:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // Register side
   output logic o_wr_en,
   output logic [1:0] o_wr_sel,
   output logic [7:0] o_wr_data,
   output logic o_rd_en,
   output logic [1:0] o_rd_sel,
   input wire logic [7:0] i_rd_data
);
   logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
   logic [31:0] awaddr_r, awaddr_nxt;
   logic [7:0] wdata_r, wdata_nxt;
   logic wstrb_r, wstrb_nxt;
   logic awready_r, awready_nxt, wready_r, wready_nxt;
   logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic wr_fire, rd_fire, wr_hit, rd_hit;

   function automatic logic hit(input logic [31:0] a);
      hit = (a[31:2] >= 30'(`SSPC_IDX_CTRL)) && (a[31:2] <= 30'(`SSPC_IDX_DATL));
   endfunction

   assign wr_fire = aw_have_r & w_have_r & ~bvalid_r;
   assign rd_fire = i_arvalid & arready_r;
   assign wr_hit = hit(awaddr_r);
   assign rd_hit = hit(i_araddr);
   // Only lane 0 carries register bits; upper lanes are ignored
   assign o_wr_en = wr_fire & wr_hit & wstrb_r;
   assign o_wr_sel = awaddr_r[3:2];
   assign o_wr_data = wdata_r;
   assign o_rd_en = rd_fire & rd_hit;
   assign o_rd_sel = i_araddr[3:2];

   always_comb begin
      aw_have_nxt = aw_have_r;
      w_have_nxt = w_have_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (i_awvalid & awready_r) begin
         aw_have_nxt = 1'b1;
         awaddr_nxt = i_awaddr;
      end
      if (i_wvalid & wready_r) begin
         w_have_nxt = 1'b1;
         wdata_nxt = i_wdata[7:0];
         wstrb_nxt = i_wstrb[0];
      end
      if (bvalid_r & i_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (wr_fire) begin
         aw_have_nxt = 1'b0;
         w_have_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = wr_hit ? `SSPC_RESP_OK : `SSPC_RESP_ERR;
      end
      if (rvalid_r & i_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (rd_fire) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = rd_hit ? i_rd_data : 8'h00;
         rresp_nxt = rd_hit ? `SSPC_RESP_OK : `SSPC_RESP_ERR;
      end
      awready_nxt = ~aw_have_nxt & ~bvalid_nxt;
      wready_nxt = ~w_have_nxt & ~bvalid_nxt;
      arready_nxt = ~rvalid_nxt;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= 32'h0000_0000;
         wdata_r <= 8'h00;
         wstrb_r <= 1'b0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= `SSPC_RESP_OK;
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 8'h00;
         rresp_r <= `SSPC_RESP_OK;
      end else begin
         aw_have_r <= aw_have_nxt;
         w_have_r <= w_have_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   assign o_awready = awready_r;
   assign o_wready = wready_r;
   assign o_bvalid = bvalid_r;
   assign o_bresp = bresp_r;
   assign o_arready = arready_r;
   assign o_rvalid = rvalid_r;
   assign o_rresp = rresp_r;
   assign o_rdata = {24'h000000, rdata_r};
endmodule

// >>> tb/sspc_far_model.sv
`timescale 1ns/10ps

// ----------------------------------------
// Far-side serial peripheral, LSB first
// ----------------------------------------
module sspc_far_model (
   // System clock
   input wire logic i_ref_clk,
   // Serial wires
   input wire logic i_sck,
   input wire logic i_so,
   output logic o_ext_sck,
   output logic o_si
);
   logic [15:0] tx_r = 16'h0000;
   logic [15:0] rx_r = 16'h0000;

   initial begin
      o_ext_sck = 1'b1;
      o_si = 1'b0;
   end

   // Data line shows the inverse of the next bit until the frame starts
   task automatic load(input logic [15:0] d);
      tx_r = d;
      o_si = ~d[0];
   endtask

   // Idles high; eight system cycles a period stays below a quarter rate
   task automatic pulses(input int n);
      repeat (n) begin
         repeat (4) @(posedge i_ref_clk);
         o_ext_sck <= 1'b0;
         repeat (4) @(posedge i_ref_clk);
         o_ext_sck <= 1'b1;
      end
   endtask

   always @(negedge i_sck) begin
      o_si <= tx_r[0];
      tx_r <= {~tx_r[0], tx_r[15:1]};
   end

   always @(posedge i_sck) rx_r <= {i_so, rx_r[15:1]};
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/10ps
`include "sspc_defines.svh"

module tb_top;
   logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
   logic [31:0] awaddr, wdata, araddr;
   logic [3:0] wstrb;
   logic awready, wready, bvalid, arready, rvalid, sck_o, sck_oe, so, done;
   logic ext_sck, si, sck_w, lst;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [33:0] exp_q[$];
   logic [1:0] eb_q[$];
   int miscompares = 0;
   int compares = 0;
   int cyc = 0;
   int divs[8] = '{1024, 256, 64, 32, 16, 8, 4, 2};
   realtime t0;

   assign sck_w = sck_oe ? sck_o : ext_sck;

   sspc_ctrl dut_u (.i_ref_clk(clk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
      .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
      .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
      .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_serial_clock_pin(sck_w),
      .o_serial_clock_pin(sck_o), .o_serial_clock_pin_oe(sck_oe), .i_serial_in_pin(si),
      .o_serial_out_pin(so), .o_xfer_done(done));

   sspc_far_model ptn_u (.i_ref_clk(clk), .i_sck(sck_w), .i_so(so), .o_ext_sck(ext_sck),
      .o_si(si));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask

   task automatic stop_test;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Whole run needs about 5000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         stop_test();
      end
   end

   function automatic logic [31:0] adr(input logic [1:0] s);
      return {14'h0, `SSPC_IDX_CTRL, 2'h0} + {28'h0, s, 2'h0};
   endfunction

   function automatic logic [7:0] stat(input logic s, input logic o, input logic b);
      return 8'h9C | {1'b0, s, o, 4'h0, b};
   endfunction

   // Address and data offered together, each released when taken
   task automatic wa(input logic [31:0] a, input logic [7:0] d, input logic [1:0] r);
      eb_q.push_back(r);
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= 4'h1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [1:0] s, input logic [7:0] d);
      wa(adr(s), d, `SSPC_RESP_OK);
   endtask

   task automatic rd(input logic [31:0] a, input logic [33:0] e);
      exp_q.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rg(input logic [1:0] s, input logic [7:0] v);
      rd(adr(s), {26'h0, v});
   endtask

   always @(posedge clk) begin
      if (rvalid && rready) check({rresp, rdata}, exp_q.pop_front());
      if (bvalid && bready) check({32'h0, bresp}, {32'h0, eb_q.pop_front()});
   end

   task automatic xfer(input logic [7:0] ctrl, output logic last);
      logic [15:0] d, pd, e, m;
      int nb;
      int tc;
      d = 16'($urandom);
      pd = 16'($urandom);
      nb = ctrl[6] ? 16 : 8;
      // The far side also clocks in the tail bits, which land above the data
      tc = ctrl[5] ? (ctrl[4] ? 2 : 1) : 0;
      m = ctrl[6] ? 16'hFFFF : 16'h00FF;
      e = ctrl[6] ? d : {8'h00, d[7:0]};
      last = ctrl[6] ? d[15] : d[7];
      wr(`SSPC_SEL_CTRL, ctrl);
      wr(`SSPC_SEL_DATL, d[7:0]);
      wr(`SSPC_SEL_DATU, d[15:8]);
      ptn_u.load(pd);
      wr(`SSPC_SEL_STAT, 8'h01);
      if (ctrl[3]) ptn_u.pulses(nb);
      while (!done) @(posedge clk);
      check({18'h0, (ptn_u.rx_r >> (16 - nb - tc)) & m}, {18'h0, e});
      if (ctrl[5]) check({33'h0, ptn_u.rx_r[15]}, {33'h0, ~ctrl[4]});
      rg(`SSPC_SEL_DATL, pd[7:0]);
      if (nb == 16) rg(`SSPC_SEL_DATU, pd[15:8]);
      if (!ctrl[5]) begin
         check({33'h0, so}, {33'h0, last});
         rg(`SSPC_SEL_STAT, stat(last, 1'b0, 1'b0));
      end
      $display("transfer test done ctrl=%0h", ctrl);
   endtask

   initial begin
      rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, wdata, araddr} = 96'h0;
      wstrb = 4'h0;
      void'($urandom(55));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rg(`SSPC_SEL_CTRL, 8'h00);
      rg(`SSPC_SEL_STAT, 8'h9C);
      check({33'h0, sck_oe}, 34'h1);
      wa(32'h0000_0010, 8'h55, `SSPC_RESP_ERR);
      rd(32'h0000_0010, {2'h2, 32'h0});
      wr(`SSPC_SEL_STAT, 8'h00);
      rg(`SSPC_SEL_STAT, 8'h9C);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         wr(`SSPC_SEL_CTRL, {5'h10, 3'(i)});
         repeat (2) @(posedge sck_o);
         t0 = $realtime;
         @(posedge sck_o);
         check(34'(int'(($realtime - t0) / 8.0)), 34'(divs[i]));
      end
      $display("prescaler test done");
      xfer(8'h06, lst);
      xfer(8'h45, lst);
      xfer(8'h08, lst);
      check({33'h0, sck_oe}, 34'h0);
      wr(`SSPC_SEL_STAT, {1'b0, lst, 6'h20});
      rg(`SSPC_SEL_STAT, stat(lst, 1'b0, 1'b0));
      ptn_u.pulses(1);
      repeat (4) @(posedge clk);
      rg(`SSPC_SEL_STAT, stat(lst, 1'b1, 1'b0));
      wr(`SSPC_SEL_STAT, {1'b0, lst, 6'h00});
      rg(`SSPC_SEL_STAT, stat(lst, 1'b0, 1'b0));
      $display("overrun test done");
      wr(`SSPC_SEL_CTRL, 8'h06);
      wr(`SSPC_SEL_STAT, 8'h40);
      check({33'h0, so}, 34'h1);
      rg(`SSPC_SEL_STAT, stat(1'b1, 1'b0, 1'b0));
      xfer(8'h26, lst);
      xfer(8'h36, lst);
      wr(`SSPC_SEL_STAT, 8'h40);
      check({33'h0, so}, 34'h0);
      $display("level and tail test done");
      wr(`SSPC_SEL_CTRL, 8'h00);
      wr(`SSPC_SEL_DATL, 8'h00);
      wr(`SSPC_SEL_STAT, 8'h01);
      rg(`SSPC_SEL_STAT, stat(1'b0, 1'b0, 1'b1));
      wr(`SSPC_SEL_CTRL, 8'h00);
      rg(`SSPC_SEL_STAT, stat(1'b0, 1'b0, 1'b0));
      $display("abort test done");
      stop_test();
   end
endmodule
